/* File: src/cse_pkg.sv */
package cse_pkg;
  // command indices
  localparam logic [5:0] CMD_SWITCH      = 6'h06;
  localparam logic [5:0] CMD_EXT_RD_SGL  = 6'h30;
  localparam logic [5:0] CMD_EXT_WR_SGL  = 6'h31;
  localparam logic [5:0] CMD_EXT_RD_MUL  = 6'h3A;
  localparam logic [5:0] CMD_EXT_WR_MUL  = 6'h3B;
  localparam logic [5:0] CMD_SYS_34      = 6'h22;
  localparam logic [5:0] CMD_SYS_35      = 6'h23;
  localparam logic [5:0] CMD_SYS_36      = 6'h24;
  localparam logic [5:0] CMD_SYS_37      = 6'h25;
  localparam logic [5:0] CMD_SYS_50      = 6'h32;
  localparam logic [5:0] CMD_SYS_57      = 6'h39;
  // switch argument fields
  localparam int SW_MODE_BIT   = 31;
  localparam int SW_RSV_HI     = 30;
  localparam int SW_RSV_LO     = 24;
  localparam int SW_G6_LO      = 20;
  localparam int SW_G5_LO      = 16;
  localparam int SW_G4_LO      = 12;
  localparam int SW_G3_LO      = 8;
  localparam int SW_G2_LO      = 4;
  localparam int SW_G1_LO      = 0;
  localparam logic [3:0] GRP_ALL_ZERO = 4'h0;
  localparam logic [3:0] GRP_ALL_ONE  = 4'hF;
  localparam logic [3:0] CMDSYS_DEFAULT = 4'h0;
  // extension argument fields
  localparam int EXT_MIO_BIT   = 31;
  localparam int EXT_FN_LO     = 27;
  localparam int EXT_B26_BIT   = 26;
  localparam int EXT_ADDR_LO   = 9;
  localparam int EXT_LEN_LO    = 0;
  // command class bit for extension commands
  localparam int CCC_EXT_BIT   = 11;
  // response length and full extension support code
  localparam logic [5:0] RESP_BITS = 6'h30;
  localparam logic [1:0] EXT_SUPPORT_ALL = 2'h3;
endpackage

/* File: src/cse_decoder.sv */
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - bit 31 check/switch; bits 30:24 zero
// - group 4 power, group 3 drive fields
// - group 2 command system, group 1 access
// - CMD34-37,50,57 meaningful only per command system
// - single read: select, function, address, length
// - single write: bit 26 masked write, mask
// - multi read: unit size bit 26, count
// - multi write decodes same fields as read
// - class bit 11 set when extension supported
// - configuration register reports extension support
module cse_decoder #(
  parameter logic [15:0] BASE_CLASSES = 16'h05B5,
  parameter logic        EXT_SGL_SUP  = 1'b1,
  parameter logic        EXT_MUL_SUP  = 1'b1
) (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CE_I,
  // command in
  input  wire logic        CMD_VALID_I,
  input  wire logic [5:0]  CMD_INDEX_I,
  input  wire logic [31:0] CMD_ARG_I,
  // decode results
  output logic             DEC_VALID_O,
  output logic             ILLEGAL_O,
  output logic             RESP_REQ_O,
  output logic             DATA_REQ_O,
  output logic             SW_MODE_O,
  output logic [3:0]       POWER_LIMIT_O,
  output logic [3:0]       DRIVE_STRENGTH_O,
  output logic [3:0]       COMMAND_SYSTEM_O,
  output logic [3:0]       ACCESS_MODE_O,
  output logic             EXT_WRITE_O,
  output logic             EXT_MULTI_O,
  output logic             MEMORY_OR_IO_SELECT_O,
  output logic [3:0]       FUNCTION_NUMBER_O,
  output logic             MASKED_WRITE_ENABLE_O,
  output logic             UNIT_32K_O,
  output logic [16:0]      EXT_ADDRESS_O,
  output logic [8:0]       LENGTH_OR_WRITE_MASK_O,
  output logic             SYS_CMD_O,
  // capability
  output logic [11:0]      SUPPORTED_COMMAND_CLASSES_O,
  output logic [1:0]       EXT_SUPPORT_O,
  // register interface
  input  wire logic [1:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O
);
  localparam logic [1:0] REG_CMDSYS = 2'h0;
  localparam logic [1:0] REG_LAST   = 2'h1;
  localparam logic [1:0] REG_CAPS   = 2'h2;

  logic [3:0]  cmdsys_q;
  logic [3:0]  last_idx_q;
  logic [31:0] last_arg_q;
  logic        ill_q;
  logic [31:0] rdata_q;

  function automatic logic is_sys_cmd(input logic [5:0] idx);
    is_sys_cmd = (idx == cse_pkg::CMD_SYS_34) || (idx == cse_pkg::CMD_SYS_35) ||
                 (idx == cse_pkg::CMD_SYS_36) || (idx == cse_pkg::CMD_SYS_37) ||
                 (idx == cse_pkg::CMD_SYS_50) || (idx == cse_pkg::CMD_SYS_57);
  endfunction

  function automatic logic grp_ok(input logic [3:0] g);
    grp_ok = (g == cse_pkg::GRP_ALL_ZERO) || (g == cse_pkg::GRP_ALL_ONE);
  endfunction

  logic is_sw;
  logic is_ext;
  logic ext_ok;
  logic sw_ok;
  logic bad;
  logic [1:0] ext_sup;

  assign ext_sup = {EXT_MUL_SUP, EXT_SGL_SUP};
  assign is_sw  = CMD_INDEX_I == cse_pkg::CMD_SWITCH;
  assign is_ext = (CMD_INDEX_I == cse_pkg::CMD_EXT_RD_SGL) ||
                  (CMD_INDEX_I == cse_pkg::CMD_EXT_WR_SGL) ||
                  (CMD_INDEX_I == cse_pkg::CMD_EXT_RD_MUL) ||
                  (CMD_INDEX_I == cse_pkg::CMD_EXT_WR_MUL);
  // single-block pair needs single support, multi pair needs multi support
  assign ext_ok = (CMD_INDEX_I[3]) ? ext_sup[1] : ext_sup[0];
  // reserved fields checked; groups 6,5 must be 0h or Fh or the switch is illegal
  assign sw_ok = (CMD_ARG_I[cse_pkg::SW_RSV_HI:cse_pkg::SW_RSV_LO] == 7'h00) &&
                 grp_ok(CMD_ARG_I[cse_pkg::SW_G6_LO +: 4]) &&
                 grp_ok(CMD_ARG_I[cse_pkg::SW_G5_LO +: 4]);
  always_comb begin
    bad = 1'b0;
    if (is_sw) begin
      bad = !sw_ok;
    end else if (is_ext) begin
      bad = !ext_ok;
      if (CMD_INDEX_I == cse_pkg::CMD_EXT_RD_SGL && CMD_ARG_I[cse_pkg::EXT_B26_BIT]) begin
        bad = 1'b1;
      end
    end else if (is_sys_cmd(CMD_INDEX_I)) begin
      bad = (cmdsys_q == cse_pkg::CMDSYS_DEFAULT);
    end
  end

  // command system selection, set by a register write, else by a switch in mode 1 whose group 2 is not Fh
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cmdsys_q <= cse_pkg::CMDSYS_DEFAULT;
    end else if (CE_I) begin
      if (WR_I && ADDR_I == REG_CMDSYS) begin
        cmdsys_q <= WDATA_I[3:0];
      end else if (CMD_VALID_I && is_sw && sw_ok && CMD_ARG_I[cse_pkg::SW_MODE_BIT] &&
                   CMD_ARG_I[cse_pkg::SW_G2_LO +: 4] != cse_pkg::GRP_ALL_ONE) begin
        cmdsys_q <= CMD_ARG_I[cse_pkg::SW_G2_LO +: 4];
      end
    end
  end

  // decoded fields
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DEC_VALID_O            <= 1'b0;
      ILLEGAL_O              <= 1'b0;
      RESP_REQ_O             <= 1'b0;
      DATA_REQ_O             <= 1'b0;
      SW_MODE_O              <= 1'b0;
      POWER_LIMIT_O          <= 4'h0;
      DRIVE_STRENGTH_O       <= 4'h0;
      ACCESS_MODE_O          <= 4'h0;
      EXT_WRITE_O            <= 1'b0;
      EXT_MULTI_O            <= 1'b0;
      MEMORY_OR_IO_SELECT_O  <= 1'b0;
      FUNCTION_NUMBER_O      <= 4'h0;
      MASKED_WRITE_ENABLE_O  <= 1'b0;
      UNIT_32K_O             <= 1'b0;
      EXT_ADDRESS_O          <= 17'h0_0000;
      LENGTH_OR_WRITE_MASK_O <= 9'h000;
      SYS_CMD_O              <= 1'b0;
    end else if (CE_I) begin
      DEC_VALID_O <= CMD_VALID_I && (is_sw || is_ext || is_sys_cmd(CMD_INDEX_I));
      RESP_REQ_O  <= CMD_VALID_I && (is_sw || is_ext) && !bad;
      DATA_REQ_O  <= CMD_VALID_I && (is_sw || is_ext) && !bad;
      ILLEGAL_O   <= CMD_VALID_I && bad;
      SYS_CMD_O   <= CMD_VALID_I && is_sys_cmd(CMD_INDEX_I) && !bad;
      if (CMD_VALID_I && is_sw && sw_ok) begin
        SW_MODE_O        <= CMD_ARG_I[cse_pkg::SW_MODE_BIT];
        POWER_LIMIT_O    <= CMD_ARG_I[cse_pkg::SW_G4_LO +: 4];
        DRIVE_STRENGTH_O <= CMD_ARG_I[cse_pkg::SW_G3_LO +: 4];
        ACCESS_MODE_O    <= CMD_ARG_I[cse_pkg::SW_G1_LO +: 4];
      end
      if (CMD_VALID_I && is_ext && !bad) begin
        EXT_WRITE_O            <= CMD_INDEX_I[0];
        EXT_MULTI_O            <= CMD_INDEX_I[3];
        MEMORY_OR_IO_SELECT_O  <= CMD_ARG_I[cse_pkg::EXT_MIO_BIT];
        FUNCTION_NUMBER_O      <= CMD_ARG_I[cse_pkg::EXT_FN_LO +: 4];
        EXT_ADDRESS_O          <= CMD_ARG_I[cse_pkg::EXT_ADDR_LO +: 17];
        LENGTH_OR_WRITE_MASK_O <= CMD_ARG_I[cse_pkg::EXT_LEN_LO +: 9];
        MASKED_WRITE_ENABLE_O  <= (CMD_INDEX_I == cse_pkg::CMD_EXT_WR_SGL) &&
                                  CMD_ARG_I[cse_pkg::EXT_B26_BIT];
        UNIT_32K_O             <= CMD_INDEX_I[3] && CMD_ARG_I[cse_pkg::EXT_B26_BIT];
      end
    end
  end

  assign COMMAND_SYSTEM_O = cmdsys_q;
  assign EXT_SUPPORT_O    = ext_sup;
  always_comb begin
    SUPPORTED_COMMAND_CLASSES_O = BASE_CLASSES[11:0];
    SUPPORTED_COMMAND_CLASSES_O[cse_pkg::CCC_EXT_BIT] = |ext_sup;
  end

  // last decoded command for software
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      last_idx_q <= 4'h0;
      last_arg_q <= 32'h0000_0000;
      ill_q      <= 1'b0;
    end else if (CE_I && CMD_VALID_I) begin
      last_idx_q <= CMD_INDEX_I[3:0];
      last_arg_q <= CMD_ARG_I;
      ill_q      <= bad;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (CE_I) begin
      rdata_q <= 32'h0000_0000;
      if (RD_I) begin
        unique case (ADDR_I)
          REG_CMDSYS: rdata_q <= {28'h000_0000, cmdsys_q};
          REG_LAST:   rdata_q <= last_arg_q;
          REG_CAPS:   rdata_q <= {15'h0000, ill_q, last_idx_q, SUPPORTED_COMMAND_CLASSES_O[11:0]};
          default:    rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign RDATA_O = rdata_q;

  chk_ccc_bit: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    SUPPORTED_COMMAND_CLASSES_O[11] == |EXT_SUPPORT_O) else $error("class bit wrong");
  chk_sw_rsv: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    CE_I && CMD_VALID_I && is_sw && CMD_ARG_I[30:24] != 7'h00 |=> ILLEGAL_O)
    else $error("reserved switch bits accepted");
  chk_rd_b26: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    CE_I && CMD_VALID_I && CMD_INDEX_I == 6'h30 && CMD_ARG_I[26] |=> ILLEGAL_O && !RESP_REQ_O)
    else $error("read bit 26 accepted");
  chk_pwr_field: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    CE_I && CMD_VALID_I && is_sw && sw_ok |=> POWER_LIMIT_O == $past(CMD_ARG_I[15:12]) &&
    DRIVE_STRENGTH_O == $past(CMD_ARG_I[11:8])) else $error("group 4/3 wrong");
  chk_acc_field: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    CE_I && CMD_VALID_I && is_sw && sw_ok |=> ACCESS_MODE_O == $past(CMD_ARG_I[3:0]))
    else $error("group 1 wrong");
  chk_sys_rsv: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    CE_I && CMD_VALID_I && is_sys_cmd(CMD_INDEX_I) && cmdsys_q == 4'h0 |=> ILLEGAL_O && !SYS_CMD_O)
    else $error("reserved index accepted");
  chk_mask_wr: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    CE_I && CMD_VALID_I && CMD_INDEX_I == 6'h31 && ext_sup[0] |=>
    MASKED_WRITE_ENABLE_O == $past(CMD_ARG_I[26])) else $error("mask enable wrong");
  chk_unit_sz: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    CE_I && CMD_VALID_I && (CMD_INDEX_I == 6'h3A || CMD_INDEX_I == 6'h3B) && ext_sup[1] |=>
    UNIT_32K_O == $past(CMD_ARG_I[26]) && EXT_ADDRESS_O == $past(CMD_ARG_I[25:9]))
    else $error("multi fields wrong");
  chk_resp_data: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    RESP_REQ_O == DATA_REQ_O) else $error("response without data");
  cov_switch: cover property (@(posedge MCLK_I) DEC_VALID_O && SW_MODE_O && !ILLEGAL_O);
  cov_mask: cover property (@(posedge MCLK_I) RESP_REQ_O && MASKED_WRITE_ENABLE_O);
  cov_multi: cover property (@(posedge MCLK_I) RESP_REQ_O && UNIT_32K_O);
  cov_sys: cover property (@(posedge MCLK_I) SYS_CMD_O);
endmodule

/* File: verif/cse_host_model.sv */
`timescale 1ns/1ps
module cse_host_model (
  // command line toward the card
  input  wire logic        clk_i,
  output logic             valid_o,
  output logic [5:0]       index_o,
  output logic [31:0]      arg_o
);
  initial begin
    valid_o = 1'b0;
    index_o = 6'h00;
    arg_o   = 32'h0000_0000;
  end
  // one-cycle command; reserved fields go out exactly as the caller built them
  task automatic issue(input logic [5:0] idx, input logic [31:0] arg);
    @(posedge clk_i);
    valid_o <= 1'b1;
    index_o <= idx;
    arg_o   <= arg;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // released lines never keep the last value
    index_o <= ~idx;
    arg_o   <= ~arg;
  endtask
endmodule

/* File: verif/card_switch_ext_cmd_decoder_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module card_switch_ext_cmd_decoder_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        cv, dv, ill, rreq, dreq, swm, extw, extm, memory_or_io_select, mwe, u32, sysc;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [1:0]  ext_sup;
  logic [5:0]  cidx;
  logic [3:0]  pwr, drv, cmdsys, acc, fn;
  logic [8:0]  len;
  logic [11:0] classes;
  logic [16:0] xaddr;
  logic [31:0] carg, rdata;
  logic [31:0] wd = 32'h0000_0000;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [5:0]  sys_idx [6] = '{cse_pkg::CMD_SYS_34, cse_pkg::CMD_SYS_35, cse_pkg::CMD_SYS_36,
                               cse_pkg::CMD_SYS_37, cse_pkg::CMD_SYS_50, cse_pkg::CMD_SYS_57};

  always #5 clk = ~clk;

  cse_host_model u_host (.clk_i(clk), .valid_o(cv), .index_o(cidx), .arg_o(carg));

  cse_decoder u_dut (
    .MCLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .CMD_VALID_I(cv), .CMD_INDEX_I(cidx),
    .CMD_ARG_I(carg), .DEC_VALID_O(dv), .ILLEGAL_O(ill), .RESP_REQ_O(rreq),
    .DATA_REQ_O(dreq), .SW_MODE_O(swm), .POWER_LIMIT_O(pwr), .DRIVE_STRENGTH_O(drv),
    .COMMAND_SYSTEM_O(cmdsys), .ACCESS_MODE_O(acc), .EXT_WRITE_O(extw), .EXT_MULTI_O(extm),
    .MEMORY_OR_IO_SELECT_O(memory_or_io_select), .FUNCTION_NUMBER_O(fn), .MASKED_WRITE_ENABLE_O(mwe),
    .UNIT_32K_O(u32), .EXT_ADDRESS_O(xaddr), .LENGTH_OR_WRITE_MASK_O(len), .SYS_CMD_O(sysc),
    .SUPPORTED_COMMAND_CLASSES_O(classes), .EXT_SUPPORT_O(ext_sup), .ADDR_I(addr),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));

  task automatic complete_run;
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic sw(input logic [31:0] a, input logic bad, input logic [3:0] sys);
    u_host.issue(cse_pkg::CMD_SWITCH, a);
    #1;
    `CHK("sw_ill", bad, ill)
    if (!bad) begin
      `CHK("sw_rsp", 2'b11, {rreq, dreq})
      `CHK("sw_fld", {a[31], a[15:8], a[3:0]}, {swm, pwr, drv, acc})
    end
    `CHK("sw_sys", sys, cmdsys)
  endtask

  task automatic sys_all(input logic bad);
    foreach (sys_idx[i]) begin
      u_host.issue(sys_idx[i], 32'h0000_0000);
      #1;
      `CHK("sys", {bad, ~bad}, {ill, sysc})
    end
  endtask

  // argument: select, function, bit 26, address, length or mask or count
  task automatic ext(input logic [5:0] idx, input logic [3:0] f, input logic b,
                     input logic w, m, bad);
    logic [31:0] a;
    a = {f[0], f, b, 17'h1_2345 ^ {13'h0000, f}, 9'h1AB ^ {5'h00, f}};
    u_host.issue(idx, a);
    #1;
    `CHK("ext_ill", bad, ill)
    if (!bad) begin
      `CHK("ext_rsp", 2'b11, {rreq, dreq})
      `CHK("ext_fld", {w, m, a}, {extw, extm, memory_or_io_select, fn, m ? u32 : mwe, xaddr, len})
    end
  endtask

  task automatic wreg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [1:0] a, input logic [31:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("classes", 12'hDB5, classes)
    `CHK("ext_sup", 2'h3, ext_sup)
    sw(32'h00F0_4321, 1'b0, 4'h0);
    sw(32'h8100_0010, 1'b1, 4'h0);
    sw(32'h805F_0010, 1'b1, 4'h0);
    sys_all(1'b1);
    sw(32'h80FF_A952, 1'b0, 4'h5);
    sys_all(1'b0);
    ext(cse_pkg::CMD_EXT_RD_SGL, 4'hA, 1'b0, 1'b0, 1'b0, 1'b0);
    ext(cse_pkg::CMD_EXT_RD_SGL, 4'h3, 1'b1, 1'b0, 1'b0, 1'b1);
    ext(cse_pkg::CMD_EXT_WR_SGL, 4'h5, 1'b1, 1'b1, 1'b0, 1'b0);
    ext(cse_pkg::CMD_EXT_WR_SGL, 4'hC, 1'b0, 1'b1, 1'b0, 1'b0);
    ext(cse_pkg::CMD_EXT_RD_MUL, 4'h9, 1'b1, 1'b0, 1'b1, 1'b0);
    ext(cse_pkg::CMD_EXT_RD_MUL, 4'h6, 1'b0, 1'b0, 1'b1, 1'b0);
    ext(cse_pkg::CMD_EXT_WR_MUL, 4'hF, 1'b1, 1'b1, 1'b1, 1'b0);
    wreg(2'h0, 32'h0000_0007);
    rreg(2'h0, 32'h0000_0007);
    `CHK("reg_sys", 4'h7, cmdsys)
    rreg(2'h3, 32'h0000_0000);
    // clock enable low: a legal switch must leave dv, rreq and cmdsys frozen
    @(posedge clk);
    ce <= 1'b0;
    u_host.issue(cse_pkg::CMD_SWITCH, 32'h80FF_A932);
    #1;
    `CHK("ce_hold", {2'b00, 4'h7}, {dv, rreq, cmdsys})
    @(posedge clk);
    ce <= 1'b1;
    complete_run();
  end
endmodule
